// ---- common/tape_byte_map.svh ----
`ifndef TAPE_BYTE_MAP_SVH
`define TAPE_BYTE_MAP_SVH
`define BYTE_WIDTH 8
`define BIT_COUNT_LAST 3'h7
`define BYTE_RESET 8'h00
`define FILL_RESET 8'h00
`endif

// ---- common/tape_byte_pkg.sv ----
package tape_byte_pkg;
    typedef logic [7:0] byte_type;
    typedef enum logic [1:0] {
        read_idle,
        read_search,
        read_bytes
    } read_mode_type;
endpackage : tape_byte_pkg

// ---- rtl/tape_serial_byte_handler.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tape_byte_map.svh"

module tape_serial_byte_handler (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] parallel_write_inputs,
    input wire logic write_byte_strobe,
    input wire logic fill_byte_load_strobe,
    input wire logic sync_byte_load_strobe,
    input wire logic write_bit_clock,
    output logic serial_write_out,
    output logic write_byte_request,
    output logic fill_underrun_flag,
    input wire logic read_bit_clock,
    input wire logic serial_read_in,
    input wire logic read_gate,
    input wire logic read_request_reset,
    input wire logic read_data_enable,
    output logic [7:0] read_data_out,
    output logic read_data_out_enable,
    output logic read_byte_request,
    output logic read_overrun_flag,
    output logic sync_byte_detected
);
    import tape_byte_pkg::*;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    localparam int SYNC_N = 8;
    logic [SYNC_N-1:0] meta;
    logic [SYNC_N-1:0] sync_now;
    logic [SYNC_N-1:0] sync_old;
    logic [SYNC_N-1:0] raw_in;
    logic [7:0] data_meta;
    logic [7:0] data_sync;

    assign raw_in = {read_data_enable, read_request_reset, read_gate, serial_read_in,
                     read_bit_clock, write_bit_clock, fill_byte_load_strobe,
                     write_byte_strobe};

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            meta <= '0;
            sync_now <= '0;
            sync_old <= '0;
            data_meta <= `BYTE_RESET;
            data_sync <= `BYTE_RESET;
        end else begin
            meta <= raw_in;
            sync_now <= meta;
            sync_old <= sync_now;
            data_meta <= parallel_write_inputs;
            data_sync <= data_meta;
        end
    end

    logic sbs_meta;
    logic sbs_now;
    logic sbs_old;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sbs_meta <= 1'b0;
            sbs_now <= 1'b0;
            sbs_old <= 1'b0;
        end else begin
            sbs_meta <= sync_byte_load_strobe;
            sbs_now <= sbs_meta;
            sbs_old <= sbs_now;
        end
    end

    logic wds_rise;
    logic fbs_rise;
    logic wck_rise;
    logic rck_fall;
    logic rg_fall;
    logic rg_high;
    logic rrr_rise;
    logic sbs_rise;
    assign wds_rise = sync_now[0] && !sync_old[0];
    assign fbs_rise = sync_now[1] && !sync_old[1];
    assign wck_rise = sync_now[2] && !sync_old[2];
    assign rck_fall = !sync_now[3] && sync_old[3];
    assign rg_high = sync_now[5];
    assign rg_fall = !sync_now[5] && sync_old[5];
    assign rrr_rise = sync_now[6] && !sync_old[6];
    assign sbs_rise = sbs_now && !sbs_old;

    // ------------------------------------------------------------
    // Write path
    // ------------------------------------------------------------
    byte_type hold_byte;
    byte_type fill_byte;
    byte_type shift_out;
    logic hold_full;
    logic [2:0] wbit;
    logic reload;
    assign reload = wck_rise && (wbit == `BIT_COUNT_LAST);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            fill_byte <= `FILL_RESET;
        end else if (fbs_rise) begin
            fill_byte <= data_sync;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            hold_byte <= `BYTE_RESET;
            hold_full <= 1'b0;
        end else if (wds_rise && !reload) begin
            hold_byte <= data_sync;
            hold_full <= 1'b1;
        end else if (reload) begin
            // A strobe in the reload cycle goes straight to the shifter
            hold_full <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            shift_out <= `FILL_RESET;
            wbit <= 3'h0;
            serial_write_out <= 1'b0;
        end else if (wck_rise) begin
            wbit <= wbit + 3'h1;
            if (reload) begin
                shift_out <= wds_rise ? data_sync : (hold_full ? hold_byte : fill_byte);
            end
            serial_write_out <= (wbit == 3'h0) ? ((hold_full && reload) ? hold_byte[0]
                                : shift_out[0]) : shift_out[wbit];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            write_byte_request <= 1'b0;
        end else if (reload && (hold_full || wds_rise)) begin
            write_byte_request <= 1'b1;
        end else if (wds_rise) begin
            write_byte_request <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            fill_underrun_flag <= 1'b0;
        end else if (reload && !hold_full && !wds_rise) begin
            fill_underrun_flag <= 1'b1;
        end else if (wds_rise) begin
            fill_underrun_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    byte_type sync_byte;
    byte_type shift_in;
    byte_type next_shift_in;
    read_mode_type mode;
    logic [2:0] rbit;
    assign next_shift_in = {sync_now[4], shift_in[7:1]};

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sync_byte <= `BYTE_RESET;
        end else if (sbs_rise) begin
            sync_byte <= data_sync;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            shift_in <= `BYTE_RESET;
            rbit <= 3'h0;
            mode <= read_idle;
            read_data_out <= `BYTE_RESET;
            read_byte_request <= 1'b0;
            read_overrun_flag <= 1'b0;
            sync_byte_detected <= 1'b0;
        end else begin
            if (rrr_rise) begin
                read_byte_request <= 1'b0;
            end
            case (mode)
                read_idle: begin
                    if (rg_fall) begin
                        mode <= read_search;
                    end
                end
                read_search: begin
                    if (rck_fall) begin
                        shift_in <= next_shift_in;
                        if (next_shift_in == sync_byte) begin
                            mode <= read_bytes;
                            rbit <= 3'h0;
                            read_data_out <= next_shift_in;
                            read_byte_request <= 1'b1;
                            sync_byte_detected <= 1'b1;
                        end
                    end
                end
                read_bytes: begin
                    if (rck_fall) begin
                        shift_in <= next_shift_in;
                        rbit <= rbit + 3'h1;
                        if (rbit == `BIT_COUNT_LAST) begin
                            read_data_out <= next_shift_in;
                            read_byte_request <= 1'b1;
                            sync_byte_detected <= (next_shift_in == sync_byte);
                            if (read_byte_request && !rrr_rise) begin
                                read_overrun_flag <= 1'b1;
                            end
                        end
                    end
                end
                default: mode <= read_idle;
            endcase
            if (rg_high) begin
                mode <= read_idle;
                read_byte_request <= 1'b0;
                read_overrun_flag <= 1'b0;
                sync_byte_detected <= 1'b0;
            end
        end
    end

    assign read_data_out_enable = sync_now[7];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence empty_reload_s;
        reload && !hold_full && !wds_rise;
    endsequence

    underrun_set_a: assert property (@(posedge clk) disable iff (reset)
        empty_reload_s |=> fill_underrun_flag && shift_out == $past(fill_byte))
        else $error("underrun did not load fill byte");
    underrun_clear_a: assert property (@(posedge clk) disable iff (reset)
        wds_rise |=> !fill_underrun_flag)
        else $error("underrun not cleared by strobe");
    request_low_a: assert property (@(posedge clk) disable iff (reset)
        wds_rise && !reload |=> !write_byte_request)
        else $error("request not dropped by strobe");
    request_set_a: assert property (@(posedge clk) disable iff (reset)
        reload && (hold_full || wds_rise) |=> write_byte_request)
        else $error("request not raised on transfer");
    hold_load_a: assert property (@(posedge clk) disable iff (reset)
        wds_rise && !reload |=> hold_full && hold_byte == $past(data_sync))
        else $error("holding register not loaded");
    fill_load_a: assert property (@(posedge clk) disable iff (reset)
        fbs_rise |=> fill_byte == $past(data_sync))
        else $error("fill register not loaded");
    shift_once_a: assert property (@(posedge clk) disable iff (reset)
        !wck_rise |=> $stable(wbit))
        else $error("bit advanced without clock edge");
    hold_move_a: assert property (@(posedge clk) disable iff (reset)
        reload && hold_full && !wds_rise |=> shift_out == $past(hold_byte) && !hold_full)
        else $error("holding byte not moved");
    read_req_clear_a: assert property (@(posedge clk) disable iff (reset)
        rrr_rise && !rck_fall |=> !read_byte_request)
        else $error("read request not cleared by reset pulse");
endmodule : tape_serial_byte_handler
`default_nettype wire

// ---- tb/tape_far_end.sv ----
`timescale 1ns/1ps
`default_nettype none

module tape_far_end (
    input wire logic serial_write_out,
    input wire logic write_byte_request,
    input wire logic fill_underrun_flag,
    output logic write_bit_clock,
    output logic read_bit_clock,
    output logic serial_read_in,
    output var tape_byte_pkg::byte_type captured_byte,
    output var int captured_count
);
    import tape_byte_pkg::*;
    byte_type shifter;
    int bit_count;
    logic last_request;
    logic last_underrun;

    // ----------------------------------------
    // Bit clock and read-after-write loopback
    // ----------------------------------------
    initial begin
        write_bit_clock = 1'b0;
        #37;
        forever begin
            #80 write_bit_clock = ~write_bit_clock;
        end
    end
    assign read_bit_clock = write_bit_clock;
    assign serial_read_in = serial_write_out;

    // ----------------------------------------
    // Byte capture, realigned when write_byte_request or fill_underrun_flag rises
    // ----------------------------------------
    initial begin
        shifter = 8'h00;
        bit_count = 0;
        captured_byte = 8'h00;
        captured_count = 0;
        last_request = 1'b0;
        last_underrun = 1'b0;
    end
    always @(negedge write_bit_clock) begin
        shifter = {serial_write_out, shifter[7:1]};
        bit_count = bit_count + 1;
        if (bit_count == 8 || (write_byte_request && !last_request) ||
            (fill_underrun_flag && !last_underrun)) begin
            captured_byte = shifter;
            captured_count = captured_count + 1;
            bit_count = 0;
        end
        last_request = write_byte_request;
        last_underrun = fill_underrun_flag;
    end
endmodule : tape_far_end

`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import tape_byte_pkg::*;
    logic clk, reset, write_byte_strobe, fill_byte_load_strobe, sync_byte_load_strobe;
    logic write_bit_clock, serial_write_out, write_byte_request, fill_underrun_flag;
    logic read_bit_clock, serial_read_in, read_gate, read_data_out_enable;
    logic read_byte_request, read_overrun_flag, sync_byte_detected, sync_seen;
    logic read_request_reset, read_data_enable;
    byte_type sync_data;
    byte_type parallel_write_inputs, read_data_out, captured_byte, fill, data, prev, seen;
    byte_type corner [3] = '{8'hA5, 8'hFF, 8'h00};
    int captured_count, errors, total_checks;

    tape_serial_byte_handler dut_u (.clk(clk), .reset(reset),
        .parallel_write_inputs(parallel_write_inputs), .write_byte_strobe(write_byte_strobe),
        .fill_byte_load_strobe(fill_byte_load_strobe),
        .sync_byte_load_strobe(sync_byte_load_strobe), .write_bit_clock(write_bit_clock),
        .serial_write_out(serial_write_out), .write_byte_request(write_byte_request),
        .fill_underrun_flag(fill_underrun_flag), .read_bit_clock(read_bit_clock),
        .serial_read_in(serial_read_in), .read_gate(read_gate),
        .read_request_reset(read_request_reset),
        .read_data_enable(read_data_enable), .read_data_out(read_data_out),
        .read_data_out_enable(read_data_out_enable), .read_byte_request(read_byte_request),
        .read_overrun_flag(read_overrun_flag), .sync_byte_detected(sync_byte_detected));

    tape_far_end far_u (.serial_write_out(serial_write_out),
        .write_byte_request(write_byte_request), .fill_underrun_flag(fill_underrun_flag),
        .write_bit_clock(write_bit_clock), .read_bit_clock(read_bit_clock),
        .serial_read_in(serial_read_in), .captured_byte(captured_byte),
        .captured_count(captured_count));

    always #5 clk = ~clk;
    always @(posedge clk) begin
        if (reset) begin
            sync_seen <= 1'b0;
            sync_data <= 8'h00;
        end else if (sync_byte_detected === 1'b1 && sync_seen !== 1'b1) begin
            sync_seen <= 1'b1;
            sync_data <= read_data_out;
        end
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input string name, input byte_type exp, input byte_type got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic report_and_stop();
        if (errors == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : report_and_stop

    // Strobes 0 hold, 1 fill, 2 sync; data stays put until the next load
    task automatic load_byte(input int which, input byte_type value);
        @(posedge clk);
        #1;
        parallel_write_inputs = value;
        write_byte_strobe = (which == 0);
        fill_byte_load_strobe = (which == 1);
        sync_byte_load_strobe = (which == 2);
        repeat (4) @(posedge clk);
        #1;
        write_byte_strobe = 1'b0;
        fill_byte_load_strobe = 1'b0;
        sync_byte_load_strobe = 1'b0;
        repeat (5) @(posedge clk);
    endtask : load_byte

    task automatic next_byte(output byte_type b);
        int start;
        int i;
        start = captured_count;
        for (i = 0; i < 300 && captured_count == start; i++) @(posedge clk);
        if (captured_count == start) begin
            errors++;
            report_and_stop();
        end
        #1;
        b = captured_byte;
    endtask : next_byte

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        errors = 0;
        total_checks = 0;
        clk = 1'b0;
        reset = 1'b1;
        read_gate = 1'b1;
        read_request_reset = 1'b0;
        read_data_enable = 1'b0;
        parallel_write_inputs = 8'h00;
        write_byte_strobe = 1'b0;
        fill_byte_load_strobe = 1'b0;
        sync_byte_load_strobe = 1'b0;
        void'($urandom(32'hA263D4D9));
        repeat (5) @(posedge clk);
        #1;
        reset = 1'b0;
        check("write_byte_request", 8'h00, {7'h00, write_byte_request});
        check("fill_underrun_flag", 8'h00, {7'h00, fill_underrun_flag});
        fill = byte_type'($urandom());
        load_byte(2, corner[0]);
        load_byte(1, fill);
        #1;
        read_gate = 1'b0;
        next_byte(seen);
        next_byte(seen);
        check("fill byte", fill, seen);
        check("fill_underrun_flag", 8'h01, {7'h00, fill_underrun_flag});
        prev = fill;
        for (int i = 0; i < 6; i++) begin
            data = (i < 3) ? corner[i] : byte_type'($urandom());
            load_byte(0, data);
            check("fill_underrun_flag", 8'h00, {7'h00, fill_underrun_flag});
            check("write_byte_request", 8'h00, {7'h00, write_byte_request});
            next_byte(seen);
            check("serial byte", prev, seen);
            check("write_byte_request", 8'h01, {7'h00, write_byte_request});
            prev = data;
        end
        next_byte(seen);
        check("last byte", prev, seen);
        check("fill_underrun_flag", 8'h01, {7'h00, fill_underrun_flag});
        next_byte(seen);
        check("repeat fill", fill, seen);
        check("sync_byte_detected", 8'h01, {7'h00, sync_seen});
        check("read_byte_request", 8'h01, {7'h00, read_byte_request});
        check("read_overrun_flag", 8'h01, {7'h00, read_overrun_flag});
        check("read_data_out_enable", 8'h00, {7'h00, read_data_out_enable});
        check("sync byte data", corner[0], sync_data);
        read_data_enable = 1'b1;
        read_request_reset = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        read_request_reset = 1'b0;
        check("read_data_out_enable", 8'h01, {7'h00, read_data_out_enable});
        check("read_overrun_flag", 8'h01, {7'h00, read_overrun_flag});
        report_and_stop();
    end
endmodule : tb_top

`default_nettype wire
